//--- design/das_pkg.sv
// constants shared by the acquisition control block and its result buffer
// assumes a single 100 MHz clock domain
package das_pkg;
    localparam int DATA_W = 14;
    localparam int NUM_CHAN = 4;
    localparam int MODE_W = 4;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 3000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_W = 8;
    // mode code field layout
    localparam int MODE_COUNT_LSB = 0;
    localparam int MODE_BANK_BIT = 2;
    localparam int MODE_PDOWN_BIT = 3;
    localparam logic [3:0] MODE_RESET = 4'h0;
    // sync vector bit positions
    localparam int SYNC_TRIG = 7;
    localparam int SYNC_CS = 6;
    localparam int SYNC_WR = 5;
    localparam int SYNC_RD = 4;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_CONVERT = 3'b010,
        ST_FLUSH = 3'b100
    } seq_state_type;
endpackage

//--- design/stream_if.sv
// valid/ready stream carrying one result word between modules
// assumes both ends share one clock
`timescale 1ns/100ps
interface stream_if #(parameter int WIDTH = 14);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

//--- design/result_fifo.sv
// result buffer: synchronous fifo with width and depth parameters
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/100ps
module result_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // filling and draining sides
    stream_if.sink fill,
    stream_if.source drain
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // honest full and empty from the occupancy count
    assign fill.ready = (count != DEPTH_C);
    assign drain.valid = (count != '0);
    assign drain.data = mem[rd_ptr];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // storage write
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= fill.data;
    end

    // pointers and occupancy
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

//--- design/das_control.sv
// control of a four-channel simultaneous-sampling converter: trigger, sequencer,
// mode write, sequential result read-out and completion flag
// assumes host strobes are asynchronous to CLK and last several clock cycles
//
// Notes on behaviour
// - a rising trigger edge in idle, outside power-down, holds the selected inputs and starts the programmed sequence.
// - the active-low completion output falls once every result of the sequence is stored.
// - the four low bus lines carry the mode code in on writes and result bits out on reads, line zero as lsb.
// - each result leaves as a 14-bit word with bit 13 the msb.
// - every channel picks input A or input B according to the programmed bank.
// - the mode is latched when chip select or the write strobe rises to end the write, and kept.
// - each programmed channel takes 3 us to convert and its result is stored in internal memory.
// - each read cycle end (chip select or read strobe rising) advances the result pointer, starting at channel one and wrapping.
`timescale 1ns/100ps
module das_control #(
    parameter int CONV_CYCLES = das_pkg::CONV_CYCLES,
    parameter int FIFO_DEPTH = das_pkg::FIFO_DEPTH
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // host strobes, active low except the trigger, whose rising edge starts a sequence
    input wire logic CS_N,
    input wire logic WR_N,
    input wire logic RD_N,
    input wire logic CONVERSION_TRIGGER,
    // shared data bus, an input and an output per line, one common output enable
    input wire logic [das_pkg::DATA_W-1:0] RESULT_BUS_IN,
    output logic [das_pkg::DATA_W-1:0] RESULT_BUS_OUT,
    output logic RESULT_BUS_OE,
    // completion flag, active low
    output logic INT_N,
    // digitised channel inputs, bank A and bank B
    input wire logic [das_pkg::DATA_W-1:0] CHAN_INPUT_A [das_pkg::NUM_CHAN],
    input wire logic [das_pkg::DATA_W-1:0] CHAN_INPUT_B [das_pkg::NUM_CHAN]
);
    localparam int CW = $clog2(CONV_CYCLES);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);

    logic [das_pkg::SYNC_W-1:0] pins;
    logic [das_pkg::SYNC_W-1:0] sync1;
    logic [das_pkg::SYNC_W-1:0] sync2;
    logic [das_pkg::SYNC_W-1:0] sync3;
    logic [das_pkg::SYNC_W-1:0] filt;
    logic trig_prev;
    logic write_prev;
    logic read_prev;
    logic [das_pkg::MODE_W-1:0] code_prev;
    logic write_active;
    logic read_active;
    logic trig_rise;
    logic write_end;
    logic read_start;
    logic read_end;
    logic start;
    logic [das_pkg::MODE_W-1:0] mode;
    logic [1:0] seq_last;
    das_pkg::seq_state_type state;
    logic [CW-1:0] conv_count;
    logic [1:0] chan;
    logic [2:0] store_idx;
    logic [1:0] read_ptr;
    logic [das_pkg::DATA_W-1:0] held [das_pkg::NUM_CHAN];
    logic [das_pkg::DATA_W-1:0] ram [das_pkg::NUM_CHAN];
    logic tick;
    logic all_stored;

    stream_if #(.WIDTH(das_pkg::DATA_W)) fill ();
    stream_if #(.WIDTH(das_pkg::DATA_W)) drain ();

    // pins gathered for the three-stage synchroniser
    assign pins = {CONVERSION_TRIGGER, CS_N, WR_N, RD_N, RESULT_BUS_IN[das_pkg::MODE_W-1:0]};

    // per-bit synchroniser; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < das_pkg::SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge CLK or posedge RESET)
            begin
                if (RESET)
                begin
                    sync1[gi] <= 1'b1;
                    sync2[gi] <= 1'b1;
                    sync3[gi] <= 1'b1;
                    filt[gi] <= 1'b1;
                end
                else
                begin
                    sync1[gi] <= pins[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                    if (sync2[gi] == sync3[gi])
                        filt[gi] <= sync3[gi];
                end
            end
        end
    endgenerate

    // bus cycle decode; chip select gates both strobes
    assign write_active = !filt[das_pkg::SYNC_CS] && !filt[das_pkg::SYNC_WR];
    assign read_active = !filt[das_pkg::SYNC_CS] && !filt[das_pkg::SYNC_RD];
    assign trig_rise = filt[das_pkg::SYNC_TRIG] && !trig_prev;
    assign write_end = write_prev && !write_active;
    assign read_start = read_active && !read_prev;
    assign read_end = read_prev && !read_active;
    // triggers during a sequence or in power-down are ignored
    assign start = trig_rise && (state == das_pkg::ST_IDLE) && !mode[das_pkg::MODE_PDOWN_BIT];

    // edge history of the filtered strobes and the code on the low lines
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            trig_prev <= 1'b1;
            write_prev <= 1'b0;
            read_prev <= 1'b0;
            code_prev <= das_pkg::MODE_RESET;
        end
        else
        begin
            trig_prev <= filt[das_pkg::SYNC_TRIG];
            write_prev <= write_active;
            read_prev <= read_active;
            code_prev <= filt[das_pkg::MODE_W-1:0];
        end
    end

    // mode register, loaded at the end of a write and kept until rewritten
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            mode <= das_pkg::MODE_RESET;
        else if (write_end)
            mode <= code_prev;
    end

    // hold the selected bank on the trigger edge
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            for (int i = 0; i < das_pkg::NUM_CHAN; i++)
                held[i] <= '0;
            seq_last <= 2'h0;
        end
        else if (start)
        begin
            for (int i = 0; i < das_pkg::NUM_CHAN; i++)
                held[i] <= mode[das_pkg::MODE_BANK_BIT] ? CHAN_INPUT_B[i] : CHAN_INPUT_A[i];
            seq_last <= mode[das_pkg::MODE_COUNT_LSB +: 2];
        end
    end

    // a channel result is offered once its conversion time has run out
    assign tick = (conv_count == CONV_LAST);
    assign fill.valid = (state == das_pkg::ST_CONVERT) && tick;
    assign fill.data = held[chan];
    assign all_stored = (store_idx == ({1'b0, seq_last} + 3'h1));

    // sequencer: convert, then wait until every result reaches memory
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            state <= das_pkg::ST_IDLE;
            conv_count <= '0;
            chan <= 2'h0;
        end
        else
        begin
            case (state)
                das_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        state <= das_pkg::ST_CONVERT;
                        conv_count <= '0;
                        chan <= 2'h0;
                    end
                end
                das_pkg::ST_CONVERT:
                begin
                    // a full buffer stalls the sequencer at the end of a channel
                    if (!tick)
                        conv_count <= conv_count + 1'b1;
                    else if (fill.ready)
                    begin
                        conv_count <= '0;
                        if (chan == seq_last)
                            state <= das_pkg::ST_FLUSH;
                        else
                            chan <= chan + 2'h1;
                    end
                end
                das_pkg::ST_FLUSH:
                begin
                    if (all_stored)
                        state <= das_pkg::ST_IDLE;
                end
                default:
                    state <= das_pkg::ST_IDLE;
            endcase
        end
    end

    result_fifo #(.WIDTH(das_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(CLK),
        .reset(RESET),
        .fill(fill),
        .drain(drain)
    );

    // memory is not updated while the host is reading it
    assign drain.ready = !read_active && (store_idx != 3'h4);

    // result memory fill
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            for (int i = 0; i < das_pkg::NUM_CHAN; i++)
                ram[i] <= '0;
            store_idx <= 3'h0;
        end
        else if (start)
            store_idx <= 3'h0;
        else if (drain.valid && drain.ready)
        begin
            ram[store_idx[1:0]] <= drain.data;
            store_idx <= store_idx + 3'h1;
        end
    end

    // completion flag: fall when all stored, rise on the first read
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            INT_N <= 1'b1;
        else if (state == das_pkg::ST_FLUSH && all_stored)
            INT_N <= 1'b0;
        else if (read_start)
            INT_N <= 1'b1;
    end

    // read pointer: channel one first, advance on each read end, wrap
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            read_ptr <= 2'h0;
        else if (start)
            read_ptr <= 2'h0;
        else if (read_end)
            read_ptr <= (read_ptr == seq_last) ? 2'h0 : read_ptr + 2'h1;
    end

    // output word register, msb on line 13, lsb on line zero
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            RESULT_BUS_OUT <= '0;
        else
            RESULT_BUS_OUT <= ram[read_ptr];
    end

    // bus driven only during a read cycle
    assign RESULT_BUS_OE = read_active;
endmodule

//--- tb/das_control_props.sv
// checker: timing relations on the converter control ports
// assumes a bind onto das_control, one clock, reset async active high
`timescale 1ns/100ps
module das_control_props #(
    parameter int CONV_CYCLES = 300
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // host strobes
    input wire logic CS_N,
    input wire logic RD_N,
    input wire logic CONVERSION_TRIGGER,
    // device outputs
    input wire logic [das_pkg::DATA_W-1:0] RESULT_BUS_OUT,
    input wire logic RESULT_BUS_OE,
    input wire logic INT_N
);
    int unsigned since_start;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // cycles since the last trigger rise, saturating
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            since_start <= 0;
        else if ($rose(CONVERSION_TRIGGER))
            since_start <= 0;
        else if (since_start < 100000)
            since_start <= since_start + 1;
    end
    // bus drive and completion flag
    oe_start_a: assert property ($rose(RESULT_BUS_OE) |-> !CS_N && !RD_N)
        else $error("bus driven without a read");
    oe_release_a: assert property ($rose(RD_N) |-> ##[1:6] !RESULT_BUS_OE)
        else $error("bus not released after read");
    cs_idle_a: assert property (CS_N [*8] |-> !RESULT_BUS_OE)
        else $error("bus driven while deselected");
    int_clear_a: assert property ($rose(RESULT_BUS_OE) && !INT_N |=> INT_N)
        else $error("completion flag not cleared by read");
    int_cause_a: assert property ($rose(INT_N) |-> $past(RESULT_BUS_OE))
        else $error("completion flag cleared without read");
    int_held_a: assert property (!INT_N && !RESULT_BUS_OE |=> !INT_N)
        else $error("completion flag dropped early");
    int_timing_a: assert property ($fell(INT_N) |-> since_start > CONV_CYCLES)
        else $error("sequence finished too soon");
    out_stable_a: assert property (RESULT_BUS_OE && $past(RESULT_BUS_OE) |-> $stable(RESULT_BUS_OUT))
        else $error("result word changed during read");
    // main scenarios
    cover property ($fell(INT_N));
    cover property ($rose(RESULT_BUS_OE) && !INT_N);
    cover property ($fell(RESULT_BUS_OE) ##1 !RESULT_BUS_OE [*2]);
endmodule

//--- tb/host_model.sv
// host model: processor side of the parallel bus, strobe tasks
// assumes strobe levels must stand several clocks for the pin filters
`timescale 1ns/100ps
module host_model (
    // clock
    input wire logic clk,
    // strobes, active low except the trigger
    output logic cs_n,
    output logic wr_n,
    output logic rd_n,
    output logic trig,
    // host side of the shared bus
    output logic [13:0] data,
    output logic data_oe,
    input wire logic [13:0] bus
);
    // idle levels from time zero
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        trig = 1'b1;
        data = 14'h0000;
        data_oe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // mode write: select, code on the low lines, low write pulse
    task automatic write_mode(input logic [3:0] code);
        cs_n = 1'b0;
        data = {10'h000, code};
        data_oe = 1'b1;
        hold(8);
        wr_n = 1'b0;
        hold(8);
        wr_n = 1'b1;
        hold(8);
        cs_n = 1'b1;
        data_oe = 1'b0;
        hold(2);
    endtask
    // mode write ended by chip select rising while the write strobe is still low
    task automatic write_mode_cs(input logic [3:0] code);
        cs_n = 1'b0;
        data = {10'h000, code};
        data_oe = 1'b1;
        hold(8);
        wr_n = 1'b0;
        hold(8);
        cs_n = 1'b1;
        hold(8);
        wr_n = 1'b1;
        data_oe = 1'b0;
        hold(2);
    endtask
    // low trigger pulse; the rise starts a sequence
    task automatic start_conv;
        trig = 1'b0;
        hold(8);
        trig = 1'b1;
    endtask
    // one read cycle, word taken while the strobe is still low
    task automatic read_word(output logic [13:0] d);
        cs_n = 1'b0;
        rd_n = 1'b0;
        hold(8);
        d = bus;
        rd_n = 1'b1;
        cs_n = 1'b1;
        hold(8);
    endtask
endmodule

//--- tb/tb_top.sv
// top testbench: host model, converter control and its property checker
// assumes das_control built with a shortened conversion count
`timescale 1ns/100ps
module tb_top;
    localparam int CC = 5;
    logic clk;
    logic reset;
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic trig;
    logic [13:0] host_data;
    logic host_oe;
    logic [13:0] bus;
    logic [13:0] bus_out;
    logic oe;
    logic int_n;
    logic [13:0] chan_a [4];
    logic [13:0] chan_b [4];
    int mismatches;
    int checks;
    // wire level; a released bus shows the inverted host value
    assign bus = oe ? bus_out : (host_oe ? host_data : ~host_data);
    das_control #(.CONV_CYCLES(CC)) dut (.CLK(clk), .RESET(reset), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n),
        .CONVERSION_TRIGGER(trig), .RESULT_BUS_IN(bus), .RESULT_BUS_OUT(bus_out), .RESULT_BUS_OE(oe),
        .INT_N(int_n), .CHAN_INPUT_A(chan_a), .CHAN_INPUT_B(chan_b));
    host_model host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .trig(trig), .data(host_data),
        .data_oe(host_oe), .bus(bus));
    always #5 clk = ~clk;
    task automatic stop_test;
        if (mismatches == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_int(output int n);
        n = 0;
        while (int_n !== 1'b0 && n < 300)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300)
        begin
            mismatches++;
            stop_test();
        end
    endtask
    // codes 0 to 7: channel count, bank, held inputs, timing, read order and wrap
    task automatic test_modes;
        logic [13:0] exp [4];
        logic [13:0] word;
        int n;
        int cnt;
        for (int code = 0; code < 8; code++)
        begin
            cnt = code % 4 + 1;
            if (code != 0)
                host.write_mode(4'(code));
            for (int i = 0; i < 4; i++)
            begin
                chan_a[i] = 14'(14'h2a05 + 14'h0410 * i + code);
                chan_b[i] = ~chan_a[i];
                exp[i] = (code >= 4) ? chan_b[i] : chan_a[i];
            end
            host.start_conv();
            repeat (8) @(posedge clk);
            #1;
            for (int i = 0; i < 4; i++)
            begin
                chan_a[i] = 14'h0000;
                chan_b[i] = 14'h0000;
            end
            wait_int(n);
            // pin filter and start take 5 cycles, storing the last result 2 more
            check(14'(n + 8 >= CC * cnt + 6 && n + 8 <= CC * cnt + 8), 14'h0001);
            for (int k = 0; k <= cnt; k++)
            begin
                host.read_word(word);
                check(word, exp[k % cnt]);
                check({13'h0000, int_n}, 14'h0001);
            end
        end
    endtask
    // write ended by chip select: bank A, two channels, read with wrap
    task automatic test_cs_write;
        logic [13:0] word;
        int n;
        for (int i = 0; i < 4; i++)
        begin
            chan_a[i] = 14'(14'h1357 + 14'h0101 * i);
            chan_b[i] = ~chan_a[i];
        end
        host.write_mode_cs(4'h1);
        host.start_conv();
        wait_int(n);
        for (int k = 0; k < 3; k++)
        begin
            host.read_word(word);
            check(word, 14'(14'h1357 + 14'h0101 * (k % 2)));
        end
    endtask
    // power-down code: a trigger must not start a sequence
    task automatic test_powerdown;
        host.write_mode(4'h8);
        host.start_conv();
        repeat (60) @(posedge clk);
        #1;
        check({13'h0000, int_n}, 14'h0001);
    endtask
    // reset, then the scenarios
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        mismatches = 0;
        checks = 0;
        for (int i = 0; i < 4; i++)
        begin
            chan_a[i] = 14'h0000;
            chan_b[i] = 14'h0000;
        end
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        test_modes();
        test_cs_write();
        test_powerdown();
        stop_test();
    end
endmodule
bind das_control das_control_props #(.CONV_CYCLES(CONV_CYCLES)) props (.CLK(CLK), .RESET(RESET),
    .CS_N(CS_N), .RD_N(RD_N), .CONVERSION_TRIGGER(CONVERSION_TRIGGER), .RESULT_BUS_OUT(RESULT_BUS_OUT),
    .RESULT_BUS_OE(RESULT_BUS_OE), .INT_N(INT_N));
